// ==== logic/acsp_pkg.sv ====
// constants and types for the converter control and serial port block
// Overview of operation
// [R1] Strobe high at conversion end: stay powered.
// [R2] Strobe low at conversion end: power down.
// [R3] Strobe falling edge: hold and start conversion.
// [R4] Conversion lasts 2.3 us, then result loads.
// [R5] Early read shifts out the previous result.
// [R6] Result load waits until active read ends.
// [R7] Late read shifts out the newest result.
// [R8] Host ends reads 100 ns before strobe falls.
// [R9] Powered down: strobe rising edge starts power-up.
// [R10] Power-up timed internally; early fall waits.
// [R11] Auto power-down: latch result, then power down.
// [R12] Host waits 2.3 us before reading result.
// [R13] Serial port works while converter powered down.
// [R14] Port enabled on first clock after read sync.
// [R15] Five wires: clock, two syncs, data out, in.
// [R16] Free-running or gated serial clock both work.
// [R17] Frame sync edges clear the serial counters.
// [R18] Extra clock edges ignored until next frame.
// [R19] Drive data on rises; release on 11th.
// [R20] Capture on falls; control updates on 13th.
// [R21] Power-down select bits choose power behaviour.
// [R22] Most significant first, result left justified.
// [R23] Durations counted in own clock cycles.
package acsp_pkg;

  // time base
  localparam int CLK_NS = 5;
  localparam int CONV_NS = 2300;
  localparam int WAKE_NS = 1500;
  localparam int TMR_W = 9;
  localparam logic [TMR_W-1:0] CONV_CYC = TMR_W'((CONV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] WAKE_CYC = TMR_W'((WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] TMR_ZERO = 9'h000;
  localparam logic [TMR_W-1:0] TMR_ONE = 9'h001;

  // serial framing
  localparam int WORD_W = 16;
  localparam int RES_W = 10;
  localparam int PAD_W = WORD_W - RES_W;
  localparam logic [PAD_W-1:0] PAD_ZERO = 6'h00;
  localparam logic [3:0] MSB_IDX = 4'hf;
  localparam logic [3:0] RD_BITS = 4'ha;
  localparam logic [3:0] WR_BITS = 4'hd;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // control word layout
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam int PD_HI_BIT = 11;
  localparam int PD_LO_BIT = 10;
  localparam logic [1:0] PD_FULL_DOWN = 2'h0;
  localparam logic [1:0] PD_PARTIAL = 2'h1;
  localparam logic [1:0] PD_AUTO_FULL = 2'h2;
  localparam logic [1:0] PD_FULL_UP = 2'h3;

  typedef enum logic [1:0] {
    ACSP_DOWN = 2'h0,
    ACSP_WAKE = 2'h1,
    ACSP_IDLE = 2'h2,
    ACSP_CONV = 2'h3
  } acsp_pwr_t;

endpackage

// ==== logic/acsp_sync.sv ====
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module acsp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ==== logic/acsp_top.sv ====
// conversion timing, power control and five-wire serial port of the converter
`timescale 1ns/1ps
module acsp_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic conversion_strobe_n,
  input wire logic sclk,
  input wire logic read_frame_sync,
  input wire logic write_frame_sync,
  input wire logic din,
  input wire logic [9:0] sample_code,
  output logic dout,
  output logic dout_oe_n,
  output logic sampler_hold,
  output logic analog_powered,
  output logic ref_powered,
  output logic [12:0] control_word
);

  typedef struct packed {
    acsp_pkg::acsp_pwr_t pwr;
    logic [acsp_pkg::TMR_W-1:0] tmr;
    logic fall_pend;
    logic ref_on;
    logic [3:0] prev;
    logic rd_armed;
    logic [3:0] rd_cnt;
    logic dout;
    logic dout_oe_n;
    logic wr_armed;
    logic [3:0] wr_cnt;
    logic [acsp_pkg::CTRL_W-1:0] wr_sr;
    logic [acsp_pkg::CTRL_W-1:0] ctrl;
    logic [acsp_pkg::WORD_W-1:0] result;
    logic load_pend;
    logic [acsp_pkg::RES_W-1:0] pend_code;
  } acsp_state_t;

  localparam acsp_state_t ST_RST = '{
    pwr: acsp_pkg::ACSP_DOWN,
    dout_oe_n: 1'b1,
    default: '0
  };

  acsp_state_t st;
  acsp_state_t next_st;

  logic strobe_s;
  logic rfs_s;
  logic tfs_s;
  logic sclk_s;
  logic din_s;

  // every strobe, sync and serial pin is resynchronised; the serial clock is sampled, not used as a clock
  // sampling sclk means gated and free-running serial clocks behave alike
  acsp_sync #(
    .W(3)
  ) u_sync_frame (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({conversion_strobe_n, read_frame_sync, write_frame_sync}),
    .q({strobe_s, rfs_s, tfs_s})
  );

  acsp_sync #(
    .W(2)
  ) u_sync_data ( // R15 R16
    .ref_clk(ref_clk),
    .rst(rst),
    .d({sclk, din}),
    .q({sclk_s, din_s})
  );

  logic strobe_rise;
  logic strobe_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic rfs_rise;
  logic tfs_fall;
  logic rd_active;
  logic conv_end;
  logic wake_end;
  logic down_at_end;
  logic [1:0] pd;

  // edge finding on the second synchroniser stage against the stored copy
  assign strobe_rise = strobe_s & ~st.prev[3];
  assign strobe_fall = ~strobe_s & st.prev[3];
  assign sclk_rise = sclk_s & ~st.prev[2];
  assign sclk_fall = ~sclk_s & st.prev[2];
  assign rfs_rise = rfs_s & ~st.prev[1]; // R14
  assign tfs_fall = ~tfs_s & st.prev[0];

  // a read is in flight from its first clock edge until the release edge
  assign rd_active = st.rd_armed && (st.rd_cnt != acsp_pkg::CNT_ZERO);
  assign pd = {st.ctrl[acsp_pkg::PD_HI_BIT], st.ctrl[acsp_pkg::PD_LO_BIT]}; // R21
  assign conv_end = (st.pwr == acsp_pkg::ACSP_CONV) &&
                    (st.tmr == acsp_pkg::CONV_CYC - acsp_pkg::TMR_ONE); // R4 R23
  assign wake_end = (st.pwr == acsp_pkg::ACSP_WAKE) &&
                    (st.tmr == acsp_pkg::WAKE_CYC - acsp_pkg::TMR_ONE); // R10 R23
  // 00 always drops power; 01 and 10 drop it only with the strobe low
  assign down_at_end = (pd == acsp_pkg::PD_FULL_DOWN) ||
                       (!strobe_s && (pd != acsp_pkg::PD_FULL_UP)); // R1 R2 R21

  // next state of the whole block
  always_comb begin
    next_st = st;
    next_st.prev = {strobe_s, sclk_s, rfs_s, tfs_s};

    // a result held back by a read goes in once the read is over
    if (st.load_pend && !rd_active) begin
      next_st.result = {st.pend_code, acsp_pkg::PAD_ZERO}; // R6 R22
      next_st.load_pend = 1'b0;
    end

    // power and conversion sequencing
    case (st.pwr)
      acsp_pkg::ACSP_DOWN: begin
        if ((pd == acsp_pkg::PD_FULL_UP) ||
            ((pd != acsp_pkg::PD_FULL_DOWN) && strobe_rise)) begin
          next_st.pwr = acsp_pkg::ACSP_WAKE; // R9
          next_st.tmr = acsp_pkg::TMR_ZERO;
          next_st.fall_pend = 1'b0;
        end
      end
      acsp_pkg::ACSP_WAKE: begin
        next_st.tmr = st.tmr + acsp_pkg::TMR_ONE;
        if (strobe_fall) begin
          next_st.fall_pend = 1'b1; // R10
        end
        if (wake_end) begin
          next_st.tmr = acsp_pkg::TMR_ZERO;
          next_st.fall_pend = 1'b0;
          // an early strobe fall is served only after power-up has timed out
          if (st.fall_pend || strobe_fall) begin
            next_st.pwr = acsp_pkg::ACSP_CONV; // R10
          end else begin
            next_st.pwr = acsp_pkg::ACSP_IDLE;
          end
        end
      end
      acsp_pkg::ACSP_IDLE: begin
        if (pd == acsp_pkg::PD_FULL_DOWN) begin
          next_st.pwr = acsp_pkg::ACSP_DOWN; // R21
        end else if (strobe_fall) begin
          next_st.pwr = acsp_pkg::ACSP_CONV; // R3
          next_st.tmr = acsp_pkg::TMR_ZERO;
        end
      end
      acsp_pkg::ACSP_CONV: begin
        next_st.tmr = st.tmr + acsp_pkg::TMR_ONE;
        if (conv_end) begin
          next_st.tmr = acsp_pkg::TMR_ZERO;
          // reading mid-update would tear the word, so the load is deferred
          if (rd_active) begin
            next_st.load_pend = 1'b1; // R6
            next_st.pend_code = sample_code;
          end else begin
            next_st.result = {sample_code, acsp_pkg::PAD_ZERO}; // R4 R7 R11 R22
            next_st.load_pend = 1'b0;
          end
          if (down_at_end) begin
            next_st.pwr = acsp_pkg::ACSP_DOWN; // R2 R11
          end else begin
            next_st.pwr = acsp_pkg::ACSP_IDLE; // R1
          end
        end
      end
      default: begin
        next_st.pwr = acsp_pkg::ACSP_DOWN;
      end
    endcase

    // partial power-down keeps the reference alive
    next_st.ref_on = (next_st.pwr != acsp_pkg::ACSP_DOWN) ||
                     (pd == acsp_pkg::PD_PARTIAL); // R21

    // serial read side; runs in every power state
    if (rfs_rise) begin
      next_st.rd_armed = 1'b1; // R17 R13
      next_st.rd_cnt = acsp_pkg::CNT_ZERO;
      next_st.dout_oe_n = 1'b1;
    end else if (st.rd_armed && sclk_rise) begin
      if (st.rd_cnt == acsp_pkg::RD_BITS) begin
        next_st.rd_armed = 1'b0; // R18 R19
        next_st.rd_cnt = acsp_pkg::CNT_ZERO;
        next_st.dout_oe_n = 1'b1;
      end else begin
        // the stored word is frozen during a read, so an early read sees
        // the previous result and a late one the newest
        next_st.dout = st.result[4'(acsp_pkg::MSB_IDX - st.rd_cnt)]; // R5 R7 R22
        next_st.dout_oe_n = 1'b0; // R14 R19
        next_st.rd_cnt = st.rd_cnt + acsp_pkg::CNT_ONE;
      end
    end

    // serial write side
    if (tfs_fall) begin
      next_st.wr_armed = 1'b1; // R17
      next_st.wr_cnt = acsp_pkg::CNT_ZERO;
    end else if (st.wr_armed) begin
      if (sclk_fall && (st.wr_cnt != acsp_pkg::WR_BITS)) begin
        next_st.wr_sr = {st.wr_sr[acsp_pkg::CTRL_W-2:0], din_s}; // R20 R22
        next_st.wr_cnt = st.wr_cnt + acsp_pkg::CNT_ONE;
      end else if (sclk_rise && (st.wr_cnt == acsp_pkg::WR_BITS)) begin
        next_st.ctrl = st.wr_sr; // R20
        next_st.wr_armed = 1'b0; // R18
      end
    end
  end

  // single state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign dout = st.dout;
  assign dout_oe_n = st.dout_oe_n;
  assign sampler_hold = (st.pwr == acsp_pkg::ACSP_CONV); // R3
  assign analog_powered = (st.pwr != acsp_pkg::ACSP_DOWN);
  assign ref_powered = st.ref_on;
  assign control_word = st.ctrl;

  // checks kept beside the logic they guard
  a_fall_starts_conv: // R3
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.pwr == acsp_pkg::ACSP_IDLE && pd != acsp_pkg::PD_FULL_DOWN && strobe_fall)
      |=> sampler_hold)
    else $error("strobe fall did not start a conversion");

  a_conv_length: // R4
  assert property (@(posedge ref_clk) disable iff (rst)
    $rose(sampler_hold) |-> ##[459:459] sampler_hold ##1 !sampler_hold)
    else $error("conversion length is not 460 cycles");

  a_mode_hold_power: // R1
  assert property (@(posedge ref_clk) disable iff (rst)
    (conv_end && strobe_s && pd != acsp_pkg::PD_FULL_DOWN)
      |=> (st.pwr == acsp_pkg::ACSP_IDLE))
    else $error("powered down with strobe high");

  a_auto_power_down: // R2
  assert property (@(posedge ref_clk) disable iff (rst)
    (conv_end && !strobe_s && pd != acsp_pkg::PD_FULL_UP) |=> !analog_powered)
    else $error("no power-down with strobe low");

  a_result_latched: // R11
  assert property (@(posedge ref_clk) disable iff (rst)
    (conv_end && !rd_active)
      |=> st.result == {$past(sample_code), acsp_pkg::PAD_ZERO})
    else $error("result not latched at conversion end");

  a_defer_load: // R6
  assert property (@(posedge ref_clk) disable iff (rst)
    (rd_active && $past(rd_active)) |-> $stable(st.result))
    else $error("result changed during a read");

  a_wake_on_rise: // R9
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.pwr == acsp_pkg::ACSP_DOWN && pd != acsp_pkg::PD_FULL_DOWN && strobe_rise)
      |=> (st.pwr == acsp_pkg::ACSP_WAKE))
    else $error("strobe rise did not start power-up");

  a_wake_time: // R10
  assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st.pwr == acsp_pkg::ACSP_WAKE)
      |-> ##299 (st.pwr == acsp_pkg::ACSP_WAKE) ##1 (st.pwr != acsp_pkg::ACSP_WAKE))
    else $error("power-up time is not 300 cycles");

  a_release_eleventh: // R19
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.rd_armed && sclk_rise && !rfs_rise && st.rd_cnt == acsp_pkg::RD_BITS)
      |=> dout_oe_n && !st.rd_armed)
    else $error("data pin not released on 11th edge");

  a_ctrl_update: // R20
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.wr_armed && !tfs_fall && sclk_rise && st.wr_cnt == acsp_pkg::WR_BITS)
      |=> control_word == $past(st.wr_sr))
    else $error("control word not updated on 13th edge");

  a_ignore_clock: // R18
  assert property (@(posedge ref_clk) disable iff (rst)
    (!st.wr_armed && !tfs_fall) |=> $stable(control_word))
    else $error("control word changed outside a frame");

  a_read_restart: // R17
  assert property (@(posedge ref_clk) disable iff (rst)
    rfs_rise |=> (st.rd_armed && st.rd_cnt == acsp_pkg::CNT_ZERO && dout_oe_n))
    else $error("read sync rise did not restart the frame");

  a_write_restart: // R17
  assert property (@(posedge ref_clk) disable iff (rst)
    tfs_fall |=> (st.wr_armed && st.wr_cnt == acsp_pkg::CNT_ZERO))
    else $error("write sync fall did not restart the frame");

  a_port_enable: // R14 R22
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.rd_armed && !rfs_rise && sclk_rise && st.rd_cnt == acsp_pkg::CNT_ZERO)
      |=> !dout_oe_n && (dout == $past(st.result[acsp_pkg::WORD_W-1])))
    else $error("first clock after read sync did not drive the top bit");

  a_result_left: // R22
  assert property (@(posedge ref_clk) disable iff (rst)
    st.result[acsp_pkg::PAD_W-1:0] == acsp_pkg::PAD_ZERO)
    else $error("result word not left justified");

  a_read_ignored: // R18
  assert property (@(posedge ref_clk) disable iff (rst)
    (!st.rd_armed && !rfs_rise) |=> ($stable(dout) && $stable(dout_oe_n)))
    else $error("data pin moved outside a read frame");

  a_fall_pended: // R10
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.pwr == acsp_pkg::ACSP_WAKE && !wake_end && strobe_fall)
      |=> (st.pwr == acsp_pkg::ACSP_WAKE && st.fall_pend))
    else $error("early strobe fall cut power-up short");

  a_pend_starts_conv: // R10
  assert property (@(posedge ref_clk) disable iff (rst)
    (wake_end && (st.fall_pend || strobe_fall)) |=> sampler_hold)
    else $error("pending conversion not started after power-up");

  a_partial_ref: // R21
  assert property (@(posedge ref_clk) disable iff (rst)
    (pd == acsp_pkg::PD_PARTIAL) |=> ref_powered)
    else $error("reference dropped in partial power-down");

  a_full_down_holds: // R21
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.pwr == acsp_pkg::ACSP_DOWN && pd == acsp_pkg::PD_FULL_DOWN) |=> !analog_powered)
    else $error("left power-down with select 00");

  a_full_up_wakes: // R21
  assert property (@(posedge ref_clk) disable iff (rst)
    (st.pwr == acsp_pkg::ACSP_DOWN && pd == acsp_pkg::PD_FULL_UP)
      |=> (st.pwr == acsp_pkg::ACSP_WAKE))
    else $error("select 11 did not start power-up");

  a_full_up_stays: // R21
  assert property (@(posedge ref_clk) disable iff (rst)
    (conv_end && pd == acsp_pkg::PD_FULL_UP) |=> analog_powered)
    else $error("powered down with select 11");

endmodule

// ==== testbench/acsp_host_model.sv ====
// serial port master model: gated clock, two frame syncs, data in and out
`timescale 1ns/1ps
module acsp_host_model (
  output logic sclk,
  output logic read_frame_sync,
  output logic write_frame_sync,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe_n
);
  // clock idles high and stands still between frames; syncs start inactive
  initial begin
    sclk = 1'b1;
    read_frame_sync = 1'b0;
    write_frame_sync = 1'b1;
    din = 1'b0;
  end

  // one frame of n clocks; dout is read at each fall, half a bit after it was driven
  task automatic frame(input logic rd, input logic wr, input logic [15:0] w, input int n,
                       output logic [15:0] r, output logic [15:0] z);
    r = 16'h0000;
    z = 16'h0000;
    read_frame_sync = rd;
    write_frame_sync = ~wr;
    #80;
    for (int i = 0; i <= n; i++) begin
      if (i < n) din = w[15-i];
      #40;
      if (i > 0) begin
        // a released pin reads back as the inverse of its last value
        r[16-i] = dout_oe_n ? ~dout : dout;
        z[16-i] = dout_oe_n;
      end
      if (i < n) sclk = 1'b0;
      #40;
      sclk = 1'b1;
    end
    // released data line must not keep its last value
    read_frame_sync = 1'b0;
    write_frame_sync = 1'b1;
    din = ~din;
    #40;
  endtask
endmodule

// ==== testbench/acsp_top_tb_top.sv ====
// self-checking bench for the converter control and serial port block
`timescale 1ns/1ps
module acsp_top_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic conversion_strobe_n = 1'b1;
  logic [9:0] sample_code = 10'h000;
  logic sclk, read_frame_sync, write_frame_sync, din, dout, dout_oe_n;
  logic sampler_hold, analog_powered, ref_powered;
  logic [12:0] control_word;
  logic [15:0] rd_word, oe_word, wr_word;
  logic [9:0] code_a;
  logic [1:0] sels [3] = '{2'h2, 2'h1, 2'h0};
  integer seed = 23266;
  int mismatches = 0;
  int num_checks = 0;
  int cnt;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  acsp_top u_dut (.ref_clk(ref_clk), .rst(rst), .conversion_strobe_n(conversion_strobe_n),
    .sclk(sclk), .read_frame_sync(read_frame_sync), .write_frame_sync(write_frame_sync),
    .din(din), .sample_code(sample_code), .dout(dout), .dout_oe_n(dout_oe_n),
    .sampler_hold(sampler_hold), .analog_powered(analog_powered),
    .ref_powered(ref_powered), .control_word(control_word));

  acsp_host_model u_host (.sclk(sclk), .read_frame_sync(read_frame_sync),
    .write_frame_sync(write_frame_sync), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // inputs always change one ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [15:0] res_word(input logic [9:0] c);
    return {c, 6'h00};
  endfunction

  // full read: ten result bits, then the pin released for the rest of the frame
  task automatic read_chk(input logic [9:0] c);
    u_host.frame(1'b1, 1'b0, 16'h0000, 16, rd_word, oe_word);
    chk("read data", res_word(c), rd_word & 16'hffc0);
    chk("read enable", 16'h003f, oe_word);
  endtask

  // full-duplex frame with random spare bits; only the top 13 bits land
  task automatic wr_sel(input logic [1:0] sel);
    wr_word = {1'b0, sel, 13'($random(seed))};
    u_host.frame(1'b1, 1'b1, wr_word, 16, rd_word, oe_word);
    cyc(2);
    chk("control word", {3'h0, wr_word[15:3]}, {3'h0, control_word});
  endtask

  // watchdog well beyond the roughly 40 us the sequence needs
  initial begin
    #200000;
    mismatches++;
    $display("[FAIL] watchdog expected finish seen timeout");
    final_report;
  end

  // main sequence
  initial begin
    cyc(4);
    chk("reset state", 16'h0001, {control_word, analog_powered, sampler_hold, dout_oe_n});
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    cyc(4);
    wr_sel(2'h3);
    cyc(320);
    chk("powered up", 16'h0001, 16'(analog_powered));
    // high-speed conversion, strobe back high before the end
    code_a = 10'($random(seed));
    sample_code = code_a;
    conversion_strobe_n = 1'b0;
    cnt = 0;
    while (sampler_hold !== 1'b1 && cnt < 10) begin
      cyc(1);
      cnt++;
    end
    chk("hold start", 16'h0001, 16'(cnt >= 3 && cnt <= 5));
    conversion_strobe_n = 1'b1;
    cnt = 0;
    while (sampler_hold === 1'b1 && cnt < 600) begin
      cyc(1);
      cnt++;
    end
    chk("hold length", 16'd460, 16'(cnt));
    chk("stay powered", 16'h0001, 16'(analog_powered));
    u_host.frame(1'b1, 1'b0, 16'h0000, 4, rd_word, oe_word);
    read_chk(code_a);
    // read begun inside the next conversion still shows the older result
    sample_code = 10'($random(seed));
    conversion_strobe_n = 1'b0;
    cyc(20);
    conversion_strobe_n = 1'b1;
    cyc(380);
    read_chk(code_a);
    cyc(10);
    read_chk(sample_code);
    // select 11 keeps power even with the strobe low at the end
    conversion_strobe_n = 1'b0;
    cyc(470);
    chk("select 11 powered", 16'h0001, 16'(analog_powered));
    chk("select 11 done", 16'h0000, 16'(sampler_hold));
    conversion_strobe_n = 1'b1;
    cyc(4);
    // automatic power-down with select codes 10 and 01; select 00 stays powered down
    foreach (sels[k]) begin
      wr_sel(sels[k]);
      conversion_strobe_n = 1'b0;
      cyc(500);
      sample_code = 10'($random(seed));
      conversion_strobe_n = 1'b1;
      cyc(50);
      conversion_strobe_n = 1'b0;
      cyc(50);
      chk("waking", 16'(sels[k] != 2'h0), 16'(analog_powered));
      if (sels[k] != 2'h0) begin
        chk("hold during wake", 16'h0000, 16'(sampler_hold));
        cyc(230);
        chk("hold after wake", 16'h0001, 16'(sampler_hold));
        cyc(470);
        chk("powered down", 16'h0000, 16'(analog_powered));
        chk("reference", 16'(sels[k] == 2'h1), 16'(ref_powered));
        read_chk(sample_code);
      end
    end
    final_report;
  end
endmodule
